// File: inc/can_mode_pkg.sv
// Package for the bus mode-control block: mode codes, timing counts, bit positions.
// Assumes one 250 MHz system clock and a bus bit time given in system clock cycles.
package can_mode_pkg;
   // Mode codes shared by the mode-request and mode-status fields
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_SLEEP = 3'h1;
   localparam logic [2:0] MODE_RESET_STATUS = 3'h4;
   // Position of the mode-request field inside the bus control register
   localparam int MODE_REQ_MSB = 7;
   localparam int MODE_REQ_LSB = 5;
   // Recessive bits that mark an idle bus
   localparam logic [3:0] IDLE_BITS = 4'hb;
   // Bus bit time in system clock cycles (default: 1 us bit at 250 MHz)
   localparam int SYS_CLK_MHZ = 250;
   localparam int BIT_TIME_NS = 1000;
   localparam logic [15:0] BIT_CYCLES = 16'(BIT_TIME_NS * SYS_CLK_MHZ / 1000);
   // Bus levels
   localparam logic RECESSIVE = 1'b1;
   localparam logic DOMINANT = 1'b0;
   // Controller state
   typedef enum logic [1:0] {ST_ACTIVE, ST_WAIT_IDLE, ST_SLEEP} ctl_state_e;
endpackage : can_mode_pkg

// File: inc/bus_idle_if.sv
// Interface between the mode controller and its idle detector.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface bus_idle_if;
   logic rx_level; // Synchronised receive level
   logic enable; // Detector counts when high
   logic idle; // Eleven recessive bits seen
   modport ctl (output rx_level, output enable, input idle);
   modport det (input rx_level, input enable, output idle);
endinterface : bus_idle_if

// File: rtl/bus_idle_detect.sv
// Idle-bus detector: counts consecutive recessive bit times on the receive line.
// Assumes a synchronised receive level and the system clock.
`timescale 1ns/1ps
module bus_idle_detect import can_mode_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   bus_idle_if.det bus
);
   logic [15:0] cyc;
   logic [15:0] next_cyc;
   logic [3:0] bits;
   logic [3:0] next_bits;
   logic idle;
   logic next_idle;

   // Any dominant level restarts the count of recessive bit times
   always_comb begin
      next_cyc = cyc;
      next_bits = bits;
      next_idle = idle;
      if (!bus.enable || bus.rx_level == DOMINANT) begin
         next_cyc = '0;
         next_bits = '0;
         next_idle = 1'b0;
      end else if (!idle) begin
         if (cyc == BIT_CYCLES - 16'h1) begin
            next_cyc = '0;
            next_bits = bits + 4'h1;
            if (bits + 4'h1 == IDLE_BITS) begin
               next_idle = 1'b1;
            end
         end else begin
            next_cyc = cyc + 16'h1;
         end
      end
   end

   // Register stage
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cyc <= '0;
         bits <= '0;
         idle <= 1'b0;
      end else begin
         cyc <= next_cyc;
         bits <= next_bits;
         idle <= next_idle;
      end
   end

   assign bus.idle = idle;
endmodule : bus_idle_detect

// File: rtl/can_sleep_wake_mode_control.sv
// Mode control of a bus controller: Normal and Disable/Sleep, wake on bus activity.
// Assumes the frame engine reports busy/done and takes the enables given here.
`timescale 1ns/1ps

// Behaviour
// - Sleep mode: no frames sent or accepted
// - Sleep keeps pending flags and error counters
// - Request code 001 asks for sleep
// - Clock stops only when no frame active
// - Active controller waits eleven recessive bits first
// - Status reads 001 only once asleep
// - Wake flag alone stays active in sleep
// - Recessive-to-dominant edge in sleep raises interrupt
// - Wake-up restores mode held before sleep
// - Frame causing wake-up is discarded
// - No error frame for lost frame
// - Transmit pin recessive throughout sleep
// - Normal mode monitors, acknowledges, signals errors
// - Own transmissions start only in Normal
// - Mode requested in bits 7:5, status reported
// - Mode change waits for pending transmissions
// - Request zero selects Normal, goes online
module can_sleep_wake_mode_control import can_mode_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_bus_control_register,
   input wire logic i_wake_detect_disable,
   input wire logic i_wake_interrupt_enable,
   input wire logic i_wake_flag_clear,
   input wire logic i_rx_pin,
   input wire logic i_engine_tx_bit,
   input wire logic i_frame_active,
   input wire logic i_tx_pending,
   input wire logic i_irq_pending,
   output logic [2:0] o_mode_status_field,
   output logic o_bus_transmit_pin,
   output logic o_engine_clk_en,
   output logic o_rx_enable,
   output logic o_tx_start_enable,
   output logic o_ack_err_enable,
   output logic o_discard_frame,
   output logic o_irq_mask_others,
   output logic o_wake_flag,
   output logic o_wake_irq
);
   logic [2:0] rx_sync;
   logic rx_prev;
   logic [2:0] req;
   ctl_state_e state;
   ctl_state_e next_state;
   logic [2:0] mode;
   logic [2:0] next_mode;
   logic [2:0] saved_mode;
   logic [2:0] next_saved_mode;
   logic wake_flag;
   logic next_wake_flag;
   logic discard;
   logic next_discard;
   logic sleep_hold;
   logic next_sleep_hold;
   logic wake_edge;
   logic rx_clean;
   bus_idle_if idle_bus ();

   assign req = i_bus_control_register[MODE_REQ_MSB:MODE_REQ_LSB];
   assign rx_clean = (rx_sync[2] == rx_sync[1]) ? rx_sync[1] : rx_prev;
   assign wake_edge = (rx_prev == RECESSIVE) && (rx_clean == DOMINANT);
   assign idle_bus.rx_level = rx_clean;
   assign idle_bus.enable = (state == ST_WAIT_IDLE);

   bus_idle_detect u_idle (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .bus(idle_bus.det)
   );

   // Receive pin synchroniser; a change counts when stages two and three agree
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_sync <= {3{RECESSIVE}};
         rx_prev <= RECESSIVE;
      end else begin
         rx_sync <= {rx_sync[1:0], i_rx_pin};
         rx_prev <= rx_clean;
      end
   end

   // Mode sequencing
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_saved_mode = saved_mode;
      next_discard = discard;
      next_sleep_hold = sleep_hold;
      case (state)
         ST_ACTIVE: begin
            // After a wake-up the old sleep code is still in the field; ignore it until rewritten
            if (req == MODE_SLEEP && !i_tx_pending && !sleep_hold) begin
               next_saved_mode = mode;
               if (i_frame_active) begin
                  next_state = ST_WAIT_IDLE;
               end else begin
                  next_state = ST_SLEEP;
                  next_mode = MODE_SLEEP;
               end
            end else if (req == MODE_NORMAL && !i_tx_pending) begin
               next_mode = MODE_NORMAL;
            end
            if (req != MODE_SLEEP) begin
               next_sleep_hold = 1'b0;
            end
            if (discard && !i_frame_active) begin
               next_discard = 1'b0;
            end
         end
         ST_WAIT_IDLE: begin
            if (req != MODE_SLEEP) begin
               next_state = ST_ACTIVE;
            end else if (idle_bus.idle && !i_tx_pending) begin
               next_state = ST_SLEEP;
               next_mode = MODE_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_edge) begin
               next_state = ST_ACTIVE;
               next_mode = saved_mode;
               next_discard = 1'b1;
               next_sleep_hold = 1'b1;
            end else if (req != MODE_SLEEP) begin
               next_state = ST_ACTIVE;
               next_mode = (req == MODE_NORMAL) ? MODE_NORMAL : saved_mode;
            end
         end
         default: begin
            next_state = ST_ACTIVE;
         end
      endcase
   end

   // Wake flag: set in sleep on bus activity, set beats clear
   always_comb begin
      next_wake_flag = wake_flag;
      if (i_wake_flag_clear) begin
         next_wake_flag = 1'b0;
      end
      if (state == ST_SLEEP && wake_edge && !i_wake_detect_disable) begin
         next_wake_flag = 1'b1;
      end
   end

   // Register stage for mode state
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_ACTIVE;
         mode <= MODE_RESET_STATUS;
         saved_mode <= MODE_RESET_STATUS;
         discard <= 1'b0;
         sleep_hold <= 1'b0;
         wake_flag <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         saved_mode <= next_saved_mode;
         discard <= next_discard;
         sleep_hold <= next_sleep_hold;
         wake_flag <= next_wake_flag;
      end
   end

   // Registered outputs; error counters and flags live outside and are never cleared here
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mode_status_field <= MODE_RESET_STATUS;
         o_bus_transmit_pin <= RECESSIVE;
         o_engine_clk_en <= 1'b1;
         o_rx_enable <= 1'b0;
         o_tx_start_enable <= 1'b0;
         o_ack_err_enable <= 1'b0;
         o_discard_frame <= 1'b0;
         o_irq_mask_others <= 1'b0;
         o_wake_flag <= 1'b0;
         o_wake_irq <= 1'b0;
      end else begin
         o_mode_status_field <= next_mode;
         o_bus_transmit_pin <= (next_state == ST_SLEEP || next_discard)
            ? RECESSIVE : i_engine_tx_bit;
         o_engine_clk_en <= (next_state != ST_SLEEP);
         o_rx_enable <= (next_state != ST_SLEEP) && !next_discard;
         o_tx_start_enable <= (next_state == ST_ACTIVE)
            && (next_mode == MODE_NORMAL);
         o_ack_err_enable <= (next_state != ST_SLEEP) && (next_mode == MODE_NORMAL)
            && !next_discard;
         o_discard_frame <= next_discard;
         o_irq_mask_others <= (next_state == ST_SLEEP) && i_irq_pending;
         o_wake_flag <= next_wake_flag;
         o_wake_irq <= next_wake_flag && i_wake_interrupt_enable;
      end
   end
endmodule : can_sleep_wake_mode_control

// File: bench/can_bus_node.sv
// Other node on the bus: idles recessive, sends a short burst.
// Assumes the bench clock; i_send starts one burst.
`timescale 1ns/1ps
module can_bus_node (
   input wire logic i_sys_clk,
   input wire logic i_send,
   output logic o_rx
);
   logic [5:0] left = 6'h00;
   initial o_rx = 1'b1;
   // Burst opens dominant, toggles, ends recessive like the pull-up
   always @(posedge i_sys_clk) begin
      if (i_send && left == 6'h00) begin
         left <= 6'h28;
         o_rx <= 1'b0;
      end else if (left != 6'h00) begin
         left <= left - 6'h01;
         o_rx <= (left == 6'h01) | left[1];
      end
   end
endmodule : can_bus_node

// File: bench/can_mode_props.sv
// Checker of the mode control outputs.
// Assumes it is bound onto the mode control top.
`timescale 1ns/1ps
module can_mode_props (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_bus_control_register,
   input wire logic i_tx_pending,
   input wire logic i_irq_pending,
   input wire logic i_wake_interrupt_enable,
   input wire logic [2:0] o_mode_status_field,
   input wire logic o_bus_transmit_pin,
   input wire logic o_engine_clk_en,
   input wire logic o_rx_enable,
   input wire logic o_tx_start_enable,
   input wire logic o_ack_err_enable,
   input wire logic o_discard_frame,
   input wire logic o_irq_mask_others,
   input wire logic o_wake_flag,
   input wire logic o_wake_irq
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic [2:0] st = o_mode_status_field;
   wire logic [2:0] req = i_bus_control_register[7:5];
   // Sleep outputs
   a_sleep_tx_idle: assert property (st == 3'h1 |-> o_bus_transmit_pin)
      else $error("tx pin dominant in sleep");
   a_sleep_no_frames: assert property (st == 3'h1 |-> !o_rx_enable && !o_tx_start_enable)
      else $error("frames allowed in sleep");
   a_sleep_clk_off: assert property (st == 3'h1 |-> !o_engine_clk_en)
      else $error("clock runs in sleep");
   a_tx_normal_only: assert property (o_tx_start_enable |-> st == 3'h0)
      else $error("tx start outside normal");
   a_sleep_by_req: assert property (st == 3'h1 && $past(st) != 3'h1 |-> $past(req) == 3'h1)
      else $error("sleep without request");
   // Wake-up and frame handling
   a_wake_discard: assert property ($past(st) == 3'h1 && st != 3'h1 && $past(req) == 3'h1
      |-> o_discard_frame)
      else $error("wake frame kept");
   a_discard_quiet: assert property (o_discard_frame |-> !o_ack_err_enable)
      else $error("error frame while discarding");
   a_normal_ack: assert property (st == 3'h0 && $past(st) == 3'h0 && !o_discard_frame
      && !$past(o_discard_frame) |-> o_ack_err_enable)
      else $error("no ack in normal");
   a_wake_irq_gate: assert property (o_wake_flag && $past(o_wake_flag)
      && i_wake_interrupt_enable && $past(i_wake_interrupt_enable) |-> o_wake_irq)
      else $error("wake irq missing");
   a_sleep_masks: assert property (st == 3'h1 && $past(st) == 3'h1 && i_irq_pending
      && $past(i_irq_pending) |-> o_irq_mask_others)
      else $error("others not masked");
   a_pending_holds: assert property ($past(i_tx_pending) && $past(st) != 3'h1
      |-> st == $past(st))
      else $error("mode changed while pending");
endmodule : can_mode_props
bind can_sleep_wake_mode_control can_mode_props props (.*);

// File: bench/test_can_sleep_wake_mode_control.sv
// Bench of the mode control: sleep entry, wake-up, blocked changes.
// Assumes the bus node model and the bound checker.
`timescale 1ns/1ps
module test_can_sleep_wake_mode_control import can_mode_pkg::*; ;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] ctl = 8'h00;
   logic dis = 1'b0, ie = 1'b0, clr = 1'b0, txb = 1'b1, fa = 1'b0, txp = 1'b0;
   logic irqp = 1'b0, send = 1'b0, rx;
   logic [2:0] st;
   logic txpin, clken, rxen, txen, acken, disc, mask, wflag, wirq;
   int err_total = 0, n_checks = 0, t;
   can_sleep_wake_mode_control DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_bus_control_register(ctl), .i_wake_detect_disable(dis),
      .i_wake_interrupt_enable(ie), .i_wake_flag_clear(clr), .i_rx_pin(rx),
      .i_engine_tx_bit(txb), .i_frame_active(fa), .i_tx_pending(txp), .i_irq_pending(irqp),
      .o_mode_status_field(st), .o_bus_transmit_pin(txpin), .o_engine_clk_en(clken),
      .o_rx_enable(rxen), .o_tx_start_enable(txen), .o_ack_err_enable(acken),
      .o_discard_frame(disc), .o_irq_mask_others(mask), .o_wake_flag(wflag), .o_wake_irq(wirq));
   can_bus_node node (.i_sys_clk(i_sys_clk), .i_send(send), .o_rx(rx));
   initial begin
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   // Control byte with the mode in its field, other bits random
   function automatic logic [7:0] req_word(input logic [2:0] m);
      return (8'($urandom) & 8'h1f) | (8'(m) << MODE_REQ_LSB);
   endfunction : req_word
   task automatic test_done;
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for a mode; t keeps the cycles spent
   task automatic wait_st(input logic [2:0] want, input int lim);
      t = 0;
      #1;
      while (st !== want && t < lim) begin
         @(posedge i_sys_clk);
         #1;
         t++;
      end
      chk(st, want);
      if (st !== want) test_done();
   endtask : wait_st
   task automatic burst;
      @(posedge i_sys_clk) send <= 1'b1;
      @(posedge i_sys_clk) send <= 1'b0;
   endtask : burst
   initial begin
      void'($urandom(60512));
      repeat (8) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      wait_st(MODE_NORMAL, 10);
      chk({txen, acken, rxen}, 3'h7);
      // Sleep and wake by bus activity, random side inputs
      for (int i = 0; i < 12; i++) begin
         @(posedge i_sys_clk);
         ie <= 1'($urandom);
         irqp <= 1'($urandom);
         txb <= 1'($urandom);
         ctl <= req_word(MODE_SLEEP);
         wait_st(MODE_SLEEP, 10);
         chk({clken, rxen, txen}, 3'h0);
         chk({txpin, mask, acken}, {1'b1, irqp, 1'b0});
         burst();
         wait_st(MODE_NORMAL, 20);
         chk({wflag, disc, acken}, 3'h6);
         chk({rxen, txen, 1'b0}, 3'h2);
         @(posedge i_sys_clk);
         ctl <= req_word(MODE_NORMAL);
         @(posedge i_sys_clk);
         #1 chk({wirq, wflag, txpin}, {ie, 1'b1, txb});
         @(posedge i_sys_clk) clr <= 1'b1;
         @(posedge i_sys_clk) clr <= 1'b0;
         #1 chk({wflag, wirq, 1'b0}, 3'h0);
         // Let the node finish its burst before the next sleep request
         repeat (40) @(posedge i_sys_clk);
      end
      // Request during a frame waits for eleven idle bits
      @(posedge i_sys_clk);
      fa <= 1'b1;
      ctl <= req_word(MODE_SLEEP);
      repeat (20) @(posedge i_sys_clk);
      fa <= 1'b0;
      #1 chk(st, MODE_NORMAL);
      chk({acken, rxen, clken}, 3'h7);
      wait_st(MODE_SLEEP, 3000);
      chk({2'h0, t + 20 >= 11 * BIT_CYCLES && t + 20 <= 11 * BIT_CYCLES + 4}, 3'h1);
      @(posedge i_sys_clk);
      ctl <= req_word(MODE_NORMAL);
      wait_st(MODE_NORMAL, 20);
      // Pending transmission holds the mode
      @(posedge i_sys_clk);
      txp <= 1'b1;
      ctl <= req_word(MODE_SLEEP);
      repeat (30) @(posedge i_sys_clk);
      #1 chk(st, MODE_NORMAL);
      @(posedge i_sys_clk);
      txp <= 1'b0;
      wait_st(MODE_SLEEP, 10);
      // Disabled wake detect leaves the flag clear
      @(posedge i_sys_clk);
      dis <= 1'b1;
      burst();
      repeat (60) @(posedge i_sys_clk);
      #1 chk({wflag, wirq, 1'b0}, 3'h0);
      test_done();
   end
endmodule : test_can_sleep_wake_mode_control
